// [include/science_link_params.svh]
// timing, sizing and reset constants for the science link receiver
`ifndef SCIENCE_LINK_PARAMS_SVH
`define SCIENCE_LINK_PARAMS_SVH
`define LINK_WORD_BITS      16
`define LINK_FIFO_DEPTH     8192
`define LINK_FIFO_AW        13
`define LINK_STAGE_DEPTH    16
`define LINK_STAGE_AW       4
`define BUS_DATA_BITS       32
`define BUS_ADDR_BITS       24
`define BUS_CS_COUNT        7
`define LINK_CLK_MHZ        1
`define CORE_CLK_MHZ        100
`define LINK_BIT_CYCLES     (`CORE_CLK_MHZ / `LINK_CLK_MHZ)
`define LINK_CNT_RST        5'h00
`define LINK_SYNC_RST       2'h0
`endif

// [include/science_link_pkg.sv]
// types shared by the science link receiver
package science_link_pkg;
  typedef logic [15:0] link_word_t;
  typedef struct packed {
    logic sclk;
    logic sdata;
  } link_pins_s;
  typedef struct packed {
    logic        overflow;
    logic        half_full;
    logic [13:0] level;
  } fifo_status_s;
endpackage

// [logic/science_link_receiver_fifo.sv]
// serial science link receiver with word fifo toward the system bus
`timescale 1ns/1ps
`include "science_link_params.svh"

// ****************************************
// word fifo
// ****************************************
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8192,
  parameter int AW    = 13
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic      [AW:0]      level
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign level     = count_r;
  assign out_data  = mem[rd_ptr_r];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + AW'(1);
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + AW'(1);
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // word_fifo

module science_link_receiver_fifo (
  input  wire logic                          core_clk,
  input  wire logic                          resetn,
  input  wire science_link_pkg::link_pins_s  link_in,
  input  wire logic                          rd_strobe,
  output logic [`BUS_DATA_BITS-1:0]          rd_data,
  output logic                               rd_valid,
  output logic                               half_full_irq,
  output logic                               overflow_err,
  input  wire logic                          overflow_clr,
  output science_link_pkg::fifo_status_s     status
);
  // ****************************************
  // reset and pin synchronisers
  // ****************************************
  logic       rst_meta_r;
  logic       rst_n;
  logic [1:0] sclk_sync_r;
  logic [1:0] sdat_sync_r;
  logic       sclk_prev_r;
  logic       sclk_rise;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_sync_r <= `LINK_SYNC_RST;
      sdat_sync_r <= `LINK_SYNC_RST;
      sclk_prev_r <= 1'b0;
    end else begin
      sclk_sync_r <= {sclk_sync_r[0], link_in.sclk};
      sdat_sync_r <= {sdat_sync_r[0], link_in.sdata};
      sclk_prev_r <= sclk_sync_r[1];
    end
  end

  assign sclk_rise = sclk_sync_r[1] && !sclk_prev_r;

  // ****************************************
  // serial to parallel
  // ****************************************
  logic [`LINK_WORD_BITS-1:0] shift_r;
  logic [4:0]                 bit_cnt_r;
  logic                       word_done;
  logic                       fifo_in_ready;
  logic [`LINK_WORD_BITS-1:0] word_nxt;

  assign word_nxt  = {shift_r[`LINK_WORD_BITS-2:0], sdat_sync_r[1]};
  assign word_done = sclk_rise && (bit_cnt_r == 5'(`LINK_WORD_BITS - 1));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_r   <= '0;
      bit_cnt_r <= `LINK_CNT_RST;
    end else if (sclk_rise) begin
      shift_r <= word_nxt;
      if (word_done) begin
        bit_cnt_r <= `LINK_CNT_RST;
      end else begin
        bit_cnt_r <= bit_cnt_r + 5'h01;
      end
    end
  end

  // ****************************************
  // staging fifo
  // ****************************************
  logic [`LINK_WORD_BITS-1:0] stage_out;
  logic                       stage_valid;
  logic                       stage_in_ready;
  logic                       overflow_set;

  word_fifo #(
    .WIDTH (`LINK_WORD_BITS),
    .DEPTH (`LINK_STAGE_DEPTH),
    .AW    (`LINK_STAGE_AW)
  ) u_stage (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (word_done),
    .in_ready  (stage_in_ready),
    .in_data   (word_nxt),
    .out_valid (stage_valid),
    .out_ready (fifo_in_ready),
    .out_data  (stage_out),
    .level     ()
  );

  assign overflow_set = word_done && !stage_in_ready;

  // ****************************************
  // fifo and read side
  // ****************************************
  logic [`LINK_WORD_BITS-1:0] fifo_out;
  logic                       fifo_out_valid;
  logic [`LINK_FIFO_AW:0]     fifo_level;

  word_fifo #(
    .WIDTH (`LINK_WORD_BITS),
    .DEPTH (`LINK_FIFO_DEPTH),
    .AW    (`LINK_FIFO_AW)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (stage_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (stage_out),
    .out_valid (fifo_out_valid),
    .out_ready (rd_strobe),
    .out_data  (fifo_out),
    .level     (fifo_level)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data  <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_strobe && fifo_out_valid;
      if (rd_strobe && fifo_out_valid) begin
        rd_data <= {16'h0000, fifo_out};
      end
    end
  end

  // ****************************************
  // status flags
  // ****************************************
  logic half_level;

  assign half_level = fifo_level >= 14'(`LINK_FIFO_DEPTH / 2);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      half_full_irq <= 1'b0;
      overflow_err  <= 1'b0;
    end else begin
      half_full_irq <= half_level;
      if (overflow_set) begin
        overflow_err <= 1'b1;
      end else if (overflow_clr) begin
        overflow_err <= 1'b0;
      end
    end
  end

  assign status = '{overflow: overflow_err, half_full: half_full_irq,
                    level: fifo_level};
endmodule // science_link_receiver_fifo

// [bench/science_link_monitor.sv]
// checker for the science link receiver ports
`timescale 1ns/1ps
`include "science_link_params.svh"
module science_link_monitor (
  input wire logic                          core_clk,
  input wire logic                          resetn,
  input wire science_link_pkg::link_pins_s  link_in,
  input wire logic                          rd_strobe,
  input wire logic [`BUS_DATA_BITS-1:0]     rd_data,
  input wire logic                          rd_valid,
  input wire logic                          half_full_irq,
  input wire logic                          overflow_err,
  input wire logic                          overflow_clr,
  input wire science_link_pkg::fifo_status_s status
);
  // *****
  // properties
  // *****
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_pop; rd_strobe && status.level != 14'h0; endsequence
  sequence s_nil; rd_strobe && status.level == 14'h0; endsequence
  property p_pop; s_pop |=> rd_valid; endproperty
  a_pop: assert property (p_pop) else $error("no read data");
  property p_nil; s_nil |=> !rd_valid; endproperty
  a_nil: assert property (p_nil) else $error("read of empty");
  property p_src; rd_valid |-> $past(rd_strobe); endproperty
  a_src: assert property (p_src) else $error("stray valid");
  property p_up; rd_valid |-> rd_data[31:16] == 16'h0; endproperty
  a_up: assert property (p_up) else $error("upper bits set");
  property p_max; status.level <= 14'h2000; endproperty
  a_max: assert property (p_max) else $error("level too big");
  property p_irq;
    half_full_irq == ($past(status.level) >= 14'h1000);
  endproperty
  a_irq: assert property (p_irq) else $error("irq differs");
  property p_lo;
    $past(status.level) < 14'h1000 && status.level < 14'h1000
      |-> !half_full_irq;
  endproperty
  a_lo: assert property (p_lo) else $error("irq below half");
  property p_stk; overflow_err && !overflow_clr |=> overflow_err; endproperty
  a_stk: assert property (p_stk) else $error("error lost");
endmodule // science_link_monitor
bind science_link_receiver_fifo science_link_monitor u_mon (
  .core_clk(core_clk), .resetn(resetn), .link_in(link_in),
  .rd_strobe(rd_strobe), .rd_data(rd_data), .rd_valid(rd_valid),
  .half_full_irq(half_full_irq), .overflow_err(overflow_err),
  .overflow_clr(overflow_clr), .status(status));

// [bench/readout_model.sv]
// serial word source standing in for the readout unit
`timescale 1ns/1ps
module readout_model (
  output science_link_pkg::link_pins_s pins
);
  initial pins = 2'h0;
  // *****
  // word sender
  // *****
  task automatic send_word(input science_link_pkg::link_word_t w);
    for (int i = 15; i >= 0; i--) begin
      pins.sdata = w[i];
      #80 pins.sclk = 1'b1;
      #80 pins.sclk = 1'b0;
    end
    pins.sdata = ~w[0];
  endtask
endmodule // readout_model

// [bench/tb_science_link_receiver_fifo.sv]
// self-checking bench for the science link receiver
`timescale 1ns/1ps
`include "science_link_params.svh"
module tb_science_link_receiver_fifo;
  logic                           core_clk = 1'b0;
  logic                           resetn = 1'b0;
  logic                           rd_strobe = 1'b0;
  logic                           overflow_clr = 1'b0;
  logic                           rd_valid, half_full_irq, overflow_err;
  logic [`BUS_DATA_BITS-1:0]      rd_data;
  science_link_pkg::link_pins_s   link_in;
  science_link_pkg::fifo_status_s status;
  int                             failures = 0;
  int                             checks = 0;
  always #5 core_clk = ~core_clk;
  readout_model u_src (.pins(link_in));
  science_link_receiver_fifo dut (.core_clk(core_clk), .resetn(resetn),
    .link_in(link_in), .rd_strobe(rd_strobe), .rd_data(rd_data),
    .rd_valid(rd_valid), .half_full_irq(half_full_irq),
    .overflow_err(overflow_err), .overflow_clr(overflow_clr),
    .status(status));
  // *****
  // helpers and scenarios
  // *****
  task automatic chk(input string n, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic pop(input logic [15:0] w, input logic v);
    @(negedge core_clk) rd_strobe = 1'b1;
    @(negedge core_clk) rd_strobe = 1'b0;
    chk("rd_valid", {31'h0, rd_valid}, {31'h0, v});
    if (v) chk("rd_data", rd_data, {16'h0, w});
  endtask
  task automatic t_stream;
    logic [15:0] w [3];
    w = '{16'h8001, 16'h7ffe, 16'ha5c3};
    foreach (w[i]) u_src.send_word(w[i]);
    repeat (8) @(negedge core_clk);
    chk("level", {18'h0, status.level}, 32'h3);
    foreach (w[i]) pop(w[i], 1'b1);
    chk("level", {18'h0, status.level}, 32'h0);
  endtask
  task automatic t_empty;
    pop(16'h0, 1'b0);
    chk("rd_data", rd_data, 32'h0000a5c3);
    @(negedge core_clk) overflow_clr = 1'b1;
    @(negedge core_clk) overflow_clr = 1'b0;
    chk("overflow_err", {31'h0, overflow_err}, 32'h0);
    chk("half_full_irq", {31'h0, half_full_irq}, 32'h0);
  endtask
  task automatic t_reset;
    u_src.send_word(16'h1234);
    @(negedge core_clk) resetn = 1'b0;
    repeat (4) @(negedge core_clk);
    resetn = 1'b1;
    repeat (6) @(negedge core_clk);
    chk("status", {16'h0, status}, 32'h0);
    chk("rd_data", rd_data, 32'h0);
    #3;
    u_src.send_word(16'h5a0f);
    repeat (8) @(negedge core_clk);
    chk("level", {18'h0, status.level}, 32'h1);
    pop(16'h5a0f, 1'b1);
  endtask
  initial begin
    #100000;
    failures++;
    test_done();
  end
  initial begin
    repeat (4) @(negedge core_clk);
    resetn = 1'b1;
    repeat (6) @(negedge core_clk);
    chk("status", {16'h0, status}, 32'h0);
    #3;
    t_stream();
    t_empty();
    t_reset();
    test_done();
  end
endmodule // tb_science_link_receiver_fifo
